// [verilog/pwrseq_pkg.sv]
`default_nettype none
package pwrseq_pkg;

  // ----------------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------------
  localparam int unsigned CLOCK_HZ        = 100_000_000;
  localparam int unsigned DEBOUNCE_MS     = 75;          // inside the 50-100 ms window
  localparam longint unsigned DEBOUNCE_CYC_L = (64'(DEBOUNCE_MS) * 64'(CLOCK_HZ)) / 64'd1000;
  localparam int unsigned DEBOUNCE_CYC    = int'(DEBOUNCE_CYC_L);
  localparam int unsigned GRACE_CYC       = 32;
  localparam int unsigned WAKE_DELAY_CYC  = 512;
  localparam int unsigned DEB_W           = 24;
  localparam int unsigned GRACE_W         = 6;
  localparam int unsigned WAKE_W          = 10;

  // ----------------------------------------------------------------------
  // wake source positions in the merged vector
  // ----------------------------------------------------------------------
  localparam int unsigned WAKE_SRC_N      = 3;
  localparam int unsigned WAKE_USER_POS   = 0;
  localparam int unsigned WAKE_CARD_POS   = 1;
  localparam int unsigned WAKE_KEYPAD_POS = 2;

  // ----------------------------------------------------------------------
  // main sequencer states, gray along off->on->grace->standby->wake
  // ----------------------------------------------------------------------
  typedef enum logic [2:0] {
    PWRSQ_OFF     = 3'b000,
    PWRSQ_ON      = 3'b001,
    PWRSQ_GRACE   = 3'b011,
    PWRSQ_STANDBY = 3'b010,
    PWRSQ_WAKE    = 3'b110,
    PWRSQ_SHUT    = 3'b100
  } pwrsq_state_t;

  // rail and clock controls driven out together
  typedef struct packed {
    logic coreSupplyOn;      // logic supply enabled
    logic porHold;           // logic held in power-on reset
    logic converterRun;      // step-up converter running
    logic converterBypass;   // bus power switched straight to intermediate_rail
    logic analogOn;          // oscillator, pll, reference and bias
    logic coreClockOn;       // processor clock and clock subsystem
    logic cardDeactivate;    // card interface deactivation request
  } pwrsq_ctrl_t;

  localparam pwrsq_ctrl_t CTRL_RESET = '{default: 1'b0};
endpackage
`default_nettype wire

// [verilog/pwrseq_sync.sv]
`timescale 1ns/1ps
`default_nettype none
// two-stage synchroniser, first stage read only by the second
module pwrseq_sync #(
  parameter int unsigned W = 1
) (
  input  wire logic         clock,
  input  wire logic         arst_n,
  input  wire logic         enable,
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] dout
);
  logic [W-1:0] stage1;

  // ----------------------------------------------------------------------
  // stages
  // ----------------------------------------------------------------------
  always_ff @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
    begin
      stage1 <= '0;
      dout   <= '0;
    end
    else if (enable)
    begin
      stage1 <= din;
      dout   <= stage1;
    end
  end
endmodule
`default_nettype wire

// [verilog/pwrseq_counter.sv]
`timescale 1ns/1ps
`default_nettype none
// up counter that pulses done when it reaches limit; clears when run drops
module pwrseq_counter #(
  parameter int unsigned W = 8
) (
  input  wire logic         clock,
  input  wire logic         arst_n,
  input  wire logic         enable,
  input  wire logic         run,
  input  wire logic [W-1:0] limit,
  output logic              done
);
  logic [W-1:0] count;

  // ----------------------------------------------------------------------
  // count while run is held, saturate at limit
  // ----------------------------------------------------------------------
  always_ff @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
    begin
      count <= '0;
      done  <= 1'b0;
    end
    else if (enable)
    begin
      if (!run)
      begin
        count <= '0;
        done  <= 1'b0;
      end
      else if (count != limit)
      begin
        count <= count + W'(1);
        done  <= (count + W'(1)) == limit;
      end
      else
        done <= 1'b0;   // one pulse only per held run
    end
  end
endmodule
`default_nettype wire

// [verilog/pwrseq_top.sv]
// Notes on behaviour
// - off: switch press powers core, holds reset
// - on: switch only requests shutdown from firmware
// - bus power forces on, switch ignored
// - power-up without bus starts off
// - off to on after debounced low press
// - long press on latches shutdown request
// - acknowledge: card off, analog off, core off
// - acknowledge alone turns off without bus
// - grounded switch powers up at once
// - bus loss while on keeps running
// - bus power, no card supply: bypass converter
// - standby gates core and clock subsystem
// - power-down with bus or on: standby
// - power-down, no bus, off: converter stops
// - 32 cycle grace before analog shutdown
// - merge three wake sources into line zero
// - wake restores power and clocks
// - wake interrupt after 512 clock count
// - power-down bit overrides individual enables
// - reading route register clears route bit
`timescale 1ns/1ps
`default_nettype none
module pwrseq_top
  import pwrseq_pkg::*;
#(
  parameter int unsigned DEBOUNCE_LIMIT = pwrseq_pkg::DEBOUNCE_CYC
) (
  input  wire logic                          clock,
  input  wire logic                          arst_n,
  input  wire logic                          clockEnable,
  input  wire logic                          onOffSwitch_n,
  input  wire logic                          busPowerPresent,
  input  wire logic                          cardSupplyRequest,
  input  wire logic                          shutdownAckBit,
  input  wire logic                          powerDownBit,
  input  wire logic                          wakeRouteSet,
  input  wire logic                          wakeSourceRegRead,
  input  wire logic [pwrseq_pkg::WAKE_SRC_N-1:0] wakeSources,
  input  wire logic                          individualAnalogOn,
  input  wire logic                          individualClockOn,
  output logic                               shutdownRequest,
  output logic                               wakeRouteBit,
  output logic                               wakeInterruptLine,
  output logic                               switchLogicOn,
  output pwrseq_pkg::pwrsq_ctrl_t            ctrl,
  output pwrseq_pkg::pwrsq_state_t           state
);
  import pwrseq_pkg::*;

  // ----------------------------------------------------------------------
  // input conditioning
  // ----------------------------------------------------------------------
  logic                  switchLow;
  logic                  busSync;
  logic [WAKE_SRC_N-1:0] wakeSync;
  logic                  switchLowRaw;
  logic                  pressDone;
  logic                  graceDone;
  logic                  wakeDone;
  logic                  wakeAny;
  logic                  ackSeen;
  logic                  pdSeen;
  pwrsq_state_t          next_state;

  assign switchLowRaw = ~onOffSwitch_n;

  // the pins come from outside the clock domain
  // switch, bus sense and wake sources share one synchroniser so that
  // they all see the same two-edge latency; the switch is inverted
  // before the first stage so that the debounce counts a pressed level
  // bus sense is only a level, so a bounce on it is harmless here:
  // the sequencer does not test powered in on; it leaves on only on an ack without bus or a power-down edge
  // limitation: a pin pulse shorter than one clock may be missed
  pwrseq_sync #(.W(2 + WAKE_SRC_N)) u_sync (
    .clock  (clock),
    .arst_n (arst_n),
    .enable (clockEnable),
    .din    ({switchLowRaw, busPowerPresent, wakeSources}),
    .dout   ({switchLow, busSync, wakeSync})
  );

  // merged wake request from user pins, card and keypad
  function automatic logic anyWake(input logic [WAKE_SRC_N-1:0] src);
    anyWake = |src;
  endfunction
  assign wakeAny = anyWake(wakeSync);

  // firmware bits are same-domain; take rising edges only
  // a level test would re-enter shutdown or grace every cycle that
  // firmware leaves the bit set; edges make each write act once
  // the power-down level is still used below to override the enables
  // both edge registers reset to the idle low level: no false edge
  logic ackPrev;
  logic pdPrev;
  always_ff @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
    begin
      ackPrev <= 1'b0;
      pdPrev  <= 1'b0;
    end
    else if (clockEnable)
    begin
      ackPrev <= shutdownAckBit;
      pdPrev  <= powerDownBit;
    end
  end
  assign ackSeen = shutdownAckBit & ~ackPrev;
  assign pdSeen  = powerDownBit & ~pdPrev;

  // ----------------------------------------------------------------------
  // timers
  // ----------------------------------------------------------------------
  // debounce restarts whenever the switch bounces high
  // the limit is a parameter so a bench can shorten the 75 ms wait;
  // the counter is wide enough for the full count at 100 MHz
  // done is a single pulse per held press, so one long press is seen
  // by the switch logic and by the request latch exactly once
  pwrseq_counter #(.W(DEB_W)) u_debounce (
    .clock  (clock),
    .arst_n (arst_n),
    .enable (clockEnable),
    .run    (switchLow),
    .limit  (DEB_W'(DEBOUNCE_LIMIT)),
    .done   (pressDone)
  );

  // grace delay and wake delay share one counter; their states never overlap
  // sharing saves a separate six-bit grace counter; the run input drops in standby,
  // which lies between the two states and clears the count before it is reused
  logic timerRun;
  logic timerDone;
  assign timerRun = (state == PWRSQ_GRACE) || (state == PWRSQ_WAKE);
  pwrseq_counter #(.W(WAKE_W)) u_timer (
    .clock  (clock),
    .arst_n (arst_n),
    .enable (clockEnable),
    .run    (timerRun),
    .limit  ((state == PWRSQ_GRACE) ? WAKE_W'(GRACE_CYC) : WAKE_W'(WAKE_DELAY_CYC)),
    .done   (timerDone)
  );
  assign graceDone = timerDone & (state == PWRSQ_GRACE);
  assign wakeDone  = timerDone & (state == PWRSQ_WAKE);

  // ----------------------------------------------------------------------
  // on/off switch logic
  // ----------------------------------------------------------------------
  // a grounded switch simply completes the debounce right after power-up
  // while bus power is present the switch state is frozen, so a press
  // made during that time neither turns the logic on nor off
  // the logic is turned off only by the shut state, never by the switch
  always_ff @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
      switchLogicOn <= 1'b0;
    else if (clockEnable)
    begin
      if (busSync)
        switchLogicOn <= switchLogicOn;
      else if (state == PWRSQ_SHUT)
        switchLogicOn <= 1'b0;
      else if (!switchLogicOn && pressDone)
        switchLogicOn <= 1'b1;
    end
  end

  // shutdown request latch: set wins, cleared only when supply goes away
  // the request ignores the switch once set, so a released button
  // cannot withdraw it; firmware must finish its work and acknowledge
  always_ff @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
      shutdownRequest <= 1'b0;
    else if (clockEnable)
    begin
      if (switchLogicOn && pressDone && !busSync)
        shutdownRequest <= 1'b1;
      else if (state == PWRSQ_OFF)
        shutdownRequest <= 1'b0;
    end
  end

  // wake route bit: set by firmware, cleared by a read, set wins
  // firmware must set it again after each read before powering down
  always_ff @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
      wakeRouteBit <= 1'b0;
    else if (clockEnable)
    begin
      if (wakeRouteSet)
        wakeRouteBit <= 1'b1;
      else if (wakeSourceRegRead)
        wakeRouteBit <= 1'b0;
    end
  end

  // ----------------------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------------------
  // powered decides between standby and full off at the end of grace
  // an acknowledge is honoured only from on; in grace, standby or wake
  // the sequencer finishes its own path first
  // hazard: without the route bit a standby can only be left by reset
  logic powered;
  assign powered = busSync | switchLogicOn;

  always_comb
  begin
    next_state = state;
    unique case (state)
      PWRSQ_OFF:
        if (powered)
          next_state = PWRSQ_ON;
      PWRSQ_ON:
        if (ackSeen && !busSync)
          next_state = PWRSQ_SHUT;
        else if (pdSeen)
          next_state = PWRSQ_GRACE;
      PWRSQ_GRACE:
        if (graceDone)
          next_state = powered ? PWRSQ_STANDBY : PWRSQ_SHUT;
      PWRSQ_STANDBY:
        if (wakeAny && wakeRouteBit)
          next_state = PWRSQ_WAKE;
      PWRSQ_WAKE:
        if (wakeDone)
          next_state = PWRSQ_ON;
      PWRSQ_SHUT:
        next_state = PWRSQ_OFF;
      default:
        next_state = PWRSQ_OFF;
    endcase
  end

  always_ff @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
      state <= PWRSQ_OFF;
    else if (clockEnable)
      state <= next_state;
  end

  // ----------------------------------------------------------------------
  // wake interrupt pulse on line zero
  // ----------------------------------------------------------------------
  // one cycle only: the line feeds an edge-sensitive interrupt input
  always_ff @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
      wakeInterruptLine <= 1'b0;
    else if (clockEnable)
      wakeInterruptLine <= wakeDone;
  end

  // ----------------------------------------------------------------------
  // rail and clock controls, registered from the next state
  // ----------------------------------------------------------------------
  // power-down overrides the individual enables once requested
  // controls follow next_state so that each rail changes on the same
  // edge as the state that wants it, and every output is a flip-flop
  // the card deactivation and supply removal share the shut cycle
  // bypass follows bus power with no card supply request so the converter can rest in suspend
  logic pdActive;
  assign pdActive = powerDownBit | (next_state == PWRSQ_STANDBY);

  always_ff @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
      ctrl <= CTRL_RESET;
    else if (clockEnable)
    begin
      ctrl.coreSupplyOn    <= (next_state != PWRSQ_OFF) && (next_state != PWRSQ_SHUT);
      ctrl.porHold         <= (state == PWRSQ_OFF) && (next_state == PWRSQ_ON);
      ctrl.converterRun    <= (next_state != PWRSQ_OFF) && (next_state != PWRSQ_SHUT)
                              && !(busSync && !cardSupplyRequest);
      ctrl.converterBypass <= busSync && !cardSupplyRequest;
      ctrl.analogOn        <= (next_state == PWRSQ_ON || next_state == PWRSQ_GRACE
                              || next_state == PWRSQ_WAKE)
                              && (pdActive ? (next_state != PWRSQ_ON || !powerDownBit)
                                           : individualAnalogOn);
      ctrl.coreClockOn     <= (next_state == PWRSQ_ON || next_state == PWRSQ_GRACE
                              || next_state == PWRSQ_WAKE)
                              && (pdActive || individualClockOn);
      ctrl.cardDeactivate  <= (next_state == PWRSQ_SHUT);
    end
  end
endmodule
`default_nettype wire

// [verification/pwrseq_fw_model.sv]
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------------------------------------
// firmware side: acks requests late, routes wake before power-down
// ----------------------------------------------------------------------
module pwrseq_fw_model #(
  parameter int unsigned ACK_DELAY = 12
) (
  input  wire logic                     clock,
  input  wire logic                     arst_n,
  input  wire logic                     sleepCmd,
  input  wire logic                     ackCmd,
  input  wire logic                     shutdownRequest,
  input  wire logic                     wakeInterruptLine,
  input  wire pwrseq_pkg::pwrsq_state_t state,
  output logic                          wakeRouteSet,
  output logic                          powerDownBit,
  output logic                          shutdownAckBit
);
  import pwrseq_pkg::*;
  logic [3:0] ackCnt;
  logic       pdArm;
  // power-down bit held as a level until the block wakes or drops off
  always_ff @(posedge clock or negedge arst_n)
    if (!arst_n)
    begin
      ackCnt         <= 4'h0;
      pdArm          <= 1'b0;
      wakeRouteSet   <= 1'b0;
      powerDownBit   <= 1'b0;
      shutdownAckBit <= 1'b0;
    end
    else
    begin
      wakeRouteSet <= sleepCmd;
      pdArm        <= sleepCmd;
      if (pdArm)
        powerDownBit <= 1'b1;
      else if (wakeInterruptLine || state == PWRSQ_OFF)
        powerDownBit <= 1'b0;
      // shutdown work takes ACK_DELAY cycles before the ack
      ackCnt         <= shutdownRequest ? ackCnt + 4'h1 : 4'h0;
      shutdownAckBit <= ackCmd || (ackCnt == 4'(ACK_DELAY));
    end
endmodule
`default_nettype wire

// [verification/pwrseq_top_asserts.sv]
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------------------------------------
// sequencer checker
// ----------------------------------------------------------------------
module pwrseq_top_asserts (
  input wire logic                     clock,
  input wire logic                     arst_n,
  input wire logic                     busPowerPresent,
  input wire logic                     wakeRouteSet,
  input wire logic                     wakeSourceRegRead,
  input wire logic                     shutdownRequest,
  input wire logic                     wakeRouteBit,
  input wire logic                     wakeInterruptLine,
  input wire pwrseq_pkg::pwrsq_ctrl_t  ctrl,
  input wire pwrseq_pkg::pwrsq_state_t state
);
  import pwrseq_pkg::*;
  pwrsq_state_t prevSt;
  logic [9:0]   stCnt;
  logic [3:0]   busHist;
  default clocking cb @(posedge clock); endclocking
  default disable iff (!arst_n);
  // dwell counter restarts on each state change, so an exit shows the dwell
  always_ff @(posedge clock or negedge arst_n)
    if (!arst_n)
    begin
      prevSt  <= PWRSQ_OFF;
      stCnt   <= 10'h000;
      busHist <= 4'h0;
    end
    else
    begin
      prevSt  <= state;
      stCnt   <= (state == prevSt) ? stCnt + 10'h001 : 10'h000;
      busHist <= {busHist[2:0], busPowerPresent};
    end
  a_grace_len: assert property (prevSt == PWRSQ_GRACE && state != PWRSQ_GRACE
    |-> stCnt >= GRACE_CYC - 1 && stCnt <= GRACE_CYC) else $error("grace length");
  a_wake_len: assert property (prevSt == PWRSQ_WAKE && state != PWRSQ_WAKE
    |-> stCnt >= WAKE_DELAY_CYC - 1 && stCnt <= WAKE_DELAY_CYC) else $error("wake length");
  a_irq_pulse: assert property (wakeInterruptLine |=> !wakeInterruptLine)
    else $error("wake pulse too long");
  a_shut_off: assert property (state == PWRSQ_SHUT |=> state == PWRSQ_OFF)
    else $error("shut not followed by off");
  a_off_rails: assert property (state == PWRSQ_OFF && prevSt == PWRSQ_OFF
    |-> !ctrl.coreSupplyOn && !ctrl.converterRun) else $error("rails up while off");
  a_por_pulse: assert property (prevSt == PWRSQ_OFF && state == PWRSQ_ON
    |-> ctrl.porHold && ctrl.coreSupplyOn ##1 !ctrl.porHold) else $error("reset hold");
  a_stby_gated: assert property (state == PWRSQ_STANDBY && prevSt == PWRSQ_STANDBY
    |-> !ctrl.coreClockOn && !ctrl.analogOn) else $error("clock live in standby");
  a_req_hold: assert property (shutdownRequest |=> shutdownRequest || state == PWRSQ_OFF)
    else $error("request dropped early");
  a_route_clear: assert property (wakeSourceRegRead && !wakeRouteSet |=> !wakeRouteBit)
    else $error("route bit kept after read");
  a_bus_holds: assert property (&busHist && busPowerPresent |-> state != PWRSQ_SHUT)
    else $error("shut with bus power");
  a_card_shut: assert property (state == PWRSQ_SHUT
    |-> ctrl.cardDeactivate && !ctrl.coreSupplyOn) else $error("card not off at shut");
  c_standby: cover property (state == PWRSQ_STANDBY);
  c_irq: cover property (wakeInterruptLine);
  c_req: cover property (shutdownRequest);
endmodule
bind pwrseq_top pwrseq_top_asserts pwrseq_top_asserts_inst (.clock, .arst_n,
  .busPowerPresent, .wakeRouteSet, .wakeSourceRegRead, .shutdownRequest,
  .wakeRouteBit, .wakeInterruptLine, .ctrl, .state);
`default_nettype wire

// [verification/pwrseq_top_test.sv]
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------------------------------------
// sequencer testbench, short debounce to keep the run small
// ----------------------------------------------------------------------
module pwrseq_top_test;
  import pwrseq_pkg::*;
  localparam int unsigned DEB = 20;
  logic         clock = 1'b0, arst_n = 1'b0, sw_n = 1'b1, bus = 1'b0, card = 1'b0;
  logic         rd = 1'b0, aOn = 1'b0, cOn = 1'b0, sleepCmd = 1'b0, ackCmd = 1'b0;
  logic [2:0]   wake = 3'h0;
  logic         shutReq, ackBit, pdBit, routeSet, routeBit, irq, swOn;
  pwrsq_ctrl_t  ctrl;
  pwrsq_state_t state;
  int           n_fail = 0, checked = 0, cyc = 0;
  always #5 clock = ~clock;
  pwrseq_top #(.DEBOUNCE_LIMIT(DEB)) pwrseq_top_inst (.clock, .arst_n, .clockEnable(1'b1),
    .onOffSwitch_n(sw_n), .busPowerPresent(bus), .cardSupplyRequest(card),
    .shutdownAckBit(ackBit), .powerDownBit(pdBit), .wakeRouteSet(routeSet),
    .wakeSourceRegRead(rd), .wakeSources(wake), .individualAnalogOn(aOn),
    .individualClockOn(cOn), .shutdownRequest(shutReq), .wakeRouteBit(routeBit),
    .wakeInterruptLine(irq), .switchLogicOn(swOn), .ctrl, .state);
  pwrseq_fw_model #(.ACK_DELAY(12)) pwrseq_fw_model_inst (.clock, .arst_n, .sleepCmd,
    .ackCmd, .shutdownRequest(shutReq), .wakeInterruptLine(irq), .state,
    .wakeRouteSet(routeSet), .powerDownBit(pdBit), .shutdownAckBit(ackBit));
  // hang guard: about five times the expected run
  always @(posedge clock)
  begin
    cyc = cyc + 1;
    if (cyc == 10000)
    begin
      n_fail = n_fail + 1;
      end_of_test();
    end
  end
  task automatic end_of_test();
    if (n_fail == 0 && checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
    checked = checked + 1;
    if (got !== exp)
    begin
      $display("MISMATCH %s expected %h seen %h", name, exp, got);
      n_fail = n_fail + 1;
    end
  endtask
  // bounded wait, then the state is judged
  task automatic waitSt(input pwrsq_state_t s, input int lim);
    int i;
    i = 0;
    while (state !== s && i < lim)
    begin
      tick(1);
      i = i + 1;
    end
    chk("state", 8'(s), 8'(state));
  endtask
  task automatic pulse(ref logic sig);
    sig = 1'b1;
    tick(1);
    sig = 1'b0;
  endtask
  // short press refused, full press powers up, bare ack powers down
  task automatic t_press();
    sw_n = 1'b0;
    tick(DEB / 2);
    sw_n = 1'b1;
    tick(2 * DEB);
    chk("state", 8'(PWRSQ_OFF), 8'(state));
    sw_n = 1'b0;
    tick(DEB);
    chk("state", 8'(PWRSQ_OFF), 8'(state));
    waitSt(PWRSQ_ON, 10);
    sw_n = 1'b1;
    chk("porHold", 8'h01, 8'(ctrl.porHold));
    tick(4);
    pulse(ackCmd);
    waitSt(PWRSQ_OFF, 6);
  endtask
  // long press while on latches a request that firmware acks
  task automatic t_request();
    sw_n = 1'b0;
    waitSt(PWRSQ_ON, DEB + 10);
    sw_n = 1'b1;
    tick(4);
    sw_n = 1'b0;
    tick(DEB + 8);
    sw_n = 1'b1;
    chk("shutdownRequest", 8'h01, 8'(shutReq));
    chk("state", 8'(PWRSQ_ON), 8'(state));
    tick(4);
    chk("shutdownRequest", 8'h01, 8'(shutReq));
    waitSt(PWRSQ_OFF, 20);
    tick(1);
    chk("shutdownRequest", 8'h00, 8'(shutReq));
  endtask
  // bus power: forced on, bypass, standby and wake from every source
  task automatic t_bus();
    int i;
    int j;
    bus = 1'b1;
    waitSt(PWRSQ_ON, DEB + 10);
    chk("converterBypass", 8'h01, 8'(ctrl.converterBypass));
    card = 1'b1;
    tick(4);
    chk("converterBypass", 8'h00, 8'(ctrl.converterBypass));
    card = 1'b0;
    pulse(ackCmd);
    tick(4);
    chk("state", 8'(PWRSQ_ON), 8'(state));
    sw_n = 1'b0;
    tick(DEB + 8);
    sw_n = 1'b1;
    chk("shutdownRequest", 8'h00, 8'(shutReq));
    for (i = 0; i < 3; i++)
    begin
      pulse(sleepCmd);
      waitSt(PWRSQ_GRACE, 6);
      tick(20);
      chk("state", 8'(PWRSQ_GRACE), 8'(state));
      waitSt(PWRSQ_STANDBY, 16);
      aOn = 1'b1;
      cOn = 1'b1;
      tick(2);
      chk("coreClockOn", 8'h00, 8'(ctrl.coreClockOn));
      chk("analogOn", 8'h00, 8'(ctrl.analogOn));
      aOn = 1'b0;
      cOn = 1'b0;
      wake[i] = 1'b1;
      tick(4);
      wake = 3'h0;
      chk("state", 8'(PWRSQ_WAKE), 8'(state));
      chk("coreClockOn", 8'h01, 8'(ctrl.coreClockOn));
      tick(500);
      j = 0;
      while (irq !== 1'b1 && j < 40)
      begin
        tick(1);
        j = j + 1;
      end
      chk("wakeInterruptLine", 8'h01, 8'(irq));
    end
    pulse(rd);
    chk("wakeRouteBit", 8'h00, 8'(routeBit));
    bus = 1'b0;
    tick(5);
    chk("state", 8'(PWRSQ_ON), 8'(state));
    chk("switchLogicOn", 8'h00, 8'(swOn));
    pulse(sleepCmd);
    waitSt(PWRSQ_OFF, 60);
  endtask
  // grounded switch powers up straight out of reset
  task automatic t_ground();
    arst_n = 1'b0;
    sw_n = 1'b0;
    tick(2);
    arst_n = 1'b1;
    waitSt(PWRSQ_ON, DEB + 10);
  endtask
  initial
  begin
    tick(16);
    arst_n = 1'b1;
    chk("state", 8'(PWRSQ_OFF), 8'(state));
    chk("ctrl", 8'h00, 8'(ctrl));
    t_press();
    t_request();
    t_bus();
    t_ground();
    end_of_test();
  end
endmodule
`default_nettype wire
